// ---- verilog/pugf_map.vh ----
// Purpose: Constants for the parameter user group filter.
// Assumes: Parameter numbers and values travel as 16-bit binary.
// Notes:   Included by pugf_filter.v only.
//
// Functional notes
// - Selector 9999 shows simple-mode parameters only
// - Selector 0 shows simple and extended
// - Selector 1 allows only group parameters
// - Group holds up to 16 numbers
// - Communication reads bypass the scope filter
// - Registration entry write adds the number
// - Clear entry write removes the number
// - Registration and clear entries read 9999
// - Clear entry accepts 9999, does nothing
// - Count entry reads number of registrations
// - Count entry write 9999 clears all
// - Other count entry writes do nothing
// - Fixed parameters always readable, contrast conditional
// - Protected parameters never enter the group
// - Installed option parameters stay readable
// - Refused group-mode write raises write error
`ifndef PUGF_MAP_VH
`define PUGF_MAP_VH

// ==========================================================
// Widths and sizes
`define PUGF_W           16
`define PUGF_NUM_W       11
`define PUGF_SLOTS       16
`define PUGF_CNT_W       5

// ==========================================================
// Selector and entry values
`define PUGF_NONE        16'h270F
`define PUGF_SCOPE_ALL   16'h0000
`define PUGF_SCOPE_GROUP 16'h0001
`define PUGF_SCOPE_SIMP  16'h270F
`define PUGF_SCOPE_RST   16'h0000
`define PUGF_PAR_MAX     16'h07CF

// ==========================================================
// Parameter numbers handled here
`define PUGF_P_WRPROT    16'h004D
`define PUGF_P_SCOPE     16'h00A0
`define PUGF_P_COUNT     16'h00AC
`define PUGF_P_REG       16'h00AD
`define PUGF_P_REM       16'h00AE
`define PUGF_P_LOCKLVL   16'h0128
`define PUGF_P_UNLOCK    16'h0129
`define PUGF_P_CONTRAST  16'h03DF

// Option parameter window, plain default
`define PUGF_OPT_FIRST   16'h07D0
`define PUGF_OPT_LAST    16'h0FFF

`endif

// ---- verilog/pugf_filter.v ----
// Purpose: Panel parameter access filter with user group store.
// Assumes: Panel and comm requests are on ref_clk; attach pins are async.
// Notes:   Answers are registered one cycle after the request.
//          The group count lags a slot change by one more edge.
//          Only the selector and the three group entries live here;
//          every other parameter value is served by the store behind.
`timescale 1ns/100ps
`include "pugf_map.vh"

module pugf_filter (
  input  wire        ref_clk,            // System clock 10 MHz
  input  wire        resetn,             // Async reset, active low
  input  wire        panelReq,           // Panel access strobe
  input  wire        panelWr,            // 1 write, 0 read
  input  wire [15:0] panelParam,         // Parameter number
  input  wire [15:0] panelWrData,        // Write value
  input  wire        panelSimple,        // Parameter is simple mode
  input  wire        commReq,            // Comm read strobe
  input  wire [15:0] commParam,          // Comm parameter number
  input  wire        displayUnitPin,     // Display unit attached
  input  wire        optionPin,          // Option module installed
  output reg         panelAck,           // Panel answer pulse
  output reg         panelAllow,         // Access granted
  output reg         panelLocal,         // Served by this block
  output reg  [15:0] panelRdData,        // Local read value
  output reg         writeRejectedError, // Write refused pulse
  output reg         commAck,            // Comm answer pulse
  output reg         commLocal,          // Comm served here
  output reg  [15:0] commRdData,         // Comm local read value
  output reg  [15:0] displayScope,       // Scope selector value
  output reg  [4:0]  groupCount          // Registered entries
);

  // ==========================================================
  // Attach pin synchronisers
  // Only the second stage is read by the filter
  reg        dispMeta;
  reg        dispSync;
  reg        optMeta;
  reg        optSync;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dispMeta <= 1'b0;
      dispSync <= 1'b0;
      optMeta  <= 1'b0;
      optSync  <= 1'b0;
    end else begin
      dispMeta <= displayUnitPin;
      dispSync <= dispMeta;
      optMeta  <= optionPin;
      optSync  <= optMeta;
    end
  end

  // ==========================================================
  // Group slot storage
  // Eleven bits per slot: every registrable number is below 2000
  wire [`PUGF_SLOTS*`PUGF_NUM_W-1:0] slotNum;
  wire [`PUGF_SLOTS-1:0]             slotVld;

  // ==========================================================
  // Decoding helpers
  // One-hot match of a number against the valid slots
  function [15:0] hitVec;
    input [15:0] p;
    integer k;
    begin
      hitVec = 16'h0000;
      for (k = 0; k < `PUGF_SLOTS; k = k + 1) begin
        if (slotVld[k] && ({5'h00, slotNum[k*`PUGF_NUM_W +: `PUGF_NUM_W]} == p))
          hitVec[k] = 1'b1;
      end
    end
  endfunction

  // Number of valid slots
  function [4:0] popCnt;
    input [15:0] v;
    integer k;
    begin
      popCnt = 5'h00;
      for (k = 0; k < `PUGF_SLOTS; k = k + 1)
        popCnt = popCnt + {4'h0, v[k]};
    end
  endfunction

  // Lowest empty slot, one-hot; zero when full
  function [15:0] firstFree;
    input [15:0] v;
    integer k;
    reg     found;
    begin
      firstFree = 16'h0000;
      found = 1'b0;
      for (k = 0; k < `PUGF_SLOTS; k = k + 1) begin
        if (!v[k] && !found) begin
          firstFree[k] = 1'b1;
          found = 1'b1;
        end
      end
    end
  endfunction

  // Numbers answered by this block itself
  function isLocal;
    input [15:0] p;
    begin
      isLocal = (p == `PUGF_P_SCOPE) || (p == `PUGF_P_COUNT) ||
                (p == `PUGF_P_REG) || (p == `PUGF_P_REM);
    end
  endfunction

  // Readable under every scope setting
  function fixedRead;
    input [15:0] p;
    begin
      fixedRead = (p == `PUGF_P_WRPROT) || (p == `PUGF_P_SCOPE) ||
                  (p == `PUGF_P_LOCKLVL) || (p == `PUGF_P_UNLOCK);
    end
  endfunction

  // Numbers that may never enter the group
  function noRegister;
    input [15:0] p;
    begin
      noRegister = fixedRead(p) || (p == `PUGF_P_COUNT) ||
                   (p == `PUGF_P_REG) || (p == `PUGF_P_REM);
    end
  endfunction

  // Window answered by an installed option
  function inOption;
    input [15:0] p;
    begin
      inOption = (p >= `PUGF_OPT_FIRST) && (p <= `PUGF_OPT_LAST);
    end
  endfunction

  // Read value of a local number
  function [15:0] localData;
    input [15:0] p;
    begin
      case (p)
        `PUGF_P_SCOPE: localData = displayScope;
        `PUGF_P_COUNT: localData = {11'h000, groupCount};
        `PUGF_P_REG:   localData = `PUGF_NONE;
        `PUGF_P_REM:   localData = `PUGF_NONE;
        default:       localData = 16'h0000;
      endcase
    end
  endfunction

  // ==========================================================
  // Access decision
  // Every check below works on the request in its own cycle
  wire [15:0] panelHit  = hitVec(panelParam);
  wire [15:0] valueHit  = hitVec(panelWrData);
  wire [15:0] freeSlot  = firstFree(slotVld);
  wire        inGroup   = |panelHit;
  wire        valInRange = (panelWrData <= `PUGF_PAR_MAX);
  wire        valNone   = (panelWrData == `PUGF_NONE);
  wire        modeAll   = (displayScope == `PUGF_SCOPE_ALL);
  wire        modeGroup = (displayScope == `PUGF_SCOPE_GROUP);
  wire        modeSimp  = (displayScope == `PUGF_SCOPE_SIMP);

  reg         scopeOk;
  reg         readOk;
  reg         writeOk;
  reg         valueBad;

  always @* begin
    scopeOk = 1'b0;
    if (modeAll)
      scopeOk = 1'b1;
    else if (modeSimp)
      scopeOk = panelSimple;
    else if (modeGroup)
      scopeOk = inGroup;
  end

  // Reads pass on scope, the fixed set, contrast with a display unit, or an installed option
  always @* begin
    readOk = scopeOk;
    if (fixedRead(panelParam))
      readOk = 1'b1;
    if ((panelParam == `PUGF_P_CONTRAST) && dispSync)
      readOk = 1'b1;
    if (inOption(panelParam) && optSync)
      readOk = 1'b1;
  end

  // Selector stays writable so a panel can never lock itself out
  always @* begin
    writeOk = scopeOk || (panelParam == `PUGF_P_SCOPE);
  end

  // Only the three scope codes may be stored
  function modeValue;
    input [15:0] v;
    begin
      modeValue = (v == `PUGF_SCOPE_ALL) || (v == `PUGF_SCOPE_GROUP) ||
                  (v == `PUGF_SCOPE_SIMP);
    end
  endfunction

  // A bad value refuses the whole write
  always @* begin
    valueBad = 1'b0;
    case (panelParam)
      `PUGF_P_SCOPE:
        valueBad = !(modeValue(panelWrData));
      `PUGF_P_REG:
        if (valNone)
          valueBad = 1'b0;
        else if (!valInRange)
          valueBad = 1'b1;
        else if (noRegister(panelWrData))
          valueBad = 1'b1;
        else if (!(|valueHit) && (freeSlot == 16'h0000))
          valueBad = 1'b1;
      `PUGF_P_REM:
        valueBad = !(valNone || valInRange);
      default:
        valueBad = 1'b0;
    endcase
  end

  // A write either lands or raises the error, never both
  wire wrTake   = panelReq && panelWr && writeOk && !valueBad;
  wire wrReject = panelReq && panelWr && !(writeOk && !valueBad);

  // ==========================================================
  // Group updates
  // add on registration write
  wire addGo  = wrTake && (panelParam == `PUGF_P_REG) && valInRange && !(|valueHit);
  wire remGo  = wrTake && (panelParam == `PUGF_P_REM) && valInRange;
  wire clrAll = wrTake && (panelParam == `PUGF_P_COUNT) && valNone;

  genvar i;
  generate
    for (i = 0; i < `PUGF_SLOTS; i = i + 1) begin : gSlot
      reg [`PUGF_NUM_W-1:0] num;
      reg                   vld;
      // Batch clear outranks remove and add
      // sixteen slots, any unprotected number below 2000
      always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          num <= 11'h000;
          vld <= 1'b0;
        end else if (clrAll) begin
          vld <= 1'b0;
        end else if (remGo && valueHit[i]) begin
          vld <= 1'b0;
        end else if (addGo && freeSlot[i]) begin
          vld <= 1'b1;
          num <= panelWrData[`PUGF_NUM_W-1:0];
        end
      end
      assign slotNum[i*`PUGF_NUM_W +: `PUGF_NUM_W] = num;
      assign slotVld[i] = vld;
    end
  endgenerate

  // Count tracks the slots one edge behind, same as any read
  // Panel readback of the count therefore sees a write two edges later
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      groupCount <= 5'h00;
    else
      groupCount <= popCnt(slotVld);
  end

  // ==========================================================
  // Selector register
  // Reset value leaves every parameter visible
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      displayScope <= `PUGF_SCOPE_RST;
    else if (wrTake && (panelParam == `PUGF_P_SCOPE))
      displayScope <= panelWrData;
  end

  // ==========================================================
  // Panel answer
  // Read data is zero unless a local read is granted
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      panelAck           <= 1'b0;
      panelAllow         <= 1'b0;
      panelLocal         <= 1'b0;
      panelRdData        <= 16'h0000;
      writeRejectedError <= 1'b0;
    end else begin
      panelAck   <= panelReq;
      panelLocal <= panelReq && isLocal(panelParam);
      if (panelReq && panelWr)
        panelAllow <= wrTake;
      else
        panelAllow <= panelReq && readOk;
      if (panelReq && !panelWr && readOk)
        panelRdData <= localData(panelParam);
      else
        panelRdData <= 16'h0000;
      writeRejectedError <= wrReject;
    end
  end

  // ==========================================================
  // Communication read answer
  // Never refused; the store serves all other numbers
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      commAck    <= 1'b0;
      commLocal  <= 1'b0;
      commRdData <= 16'h0000;
    end else begin
      commAck    <= commReq;
      commLocal  <= commReq && isLocal(commParam);
      if (commReq)
        commRdData <= localData(commParam);
      else
        commRdData <= 16'h0000;
    end
  end

endmodule // pugf_filter

// ---- bench/pugf_filter_asserts.sv ----
// Purpose: Port assertions for pugf_filter.
// Assumes: Bound to the design top.
// Notes:   Local numbers are 160 and 172 to 174.
`timescale 1ns/100ps
module pugf_filter_asserts (
  input wire        ref_clk,            // Clock
  input wire        resetn,             // Reset
  input wire        panelReq,           // Request
  input wire        panelWr,            // Write
  input wire [15:0] panelParam,         // Number
  input wire [15:0] panelWrData,        // Value
  input wire        commReq,            // Comm request
  input wire        panelAck,           // Answer
  input wire        panelAllow,         // Granted
  input wire [15:0] panelRdData,        // Read value
  input wire        writeRejectedError, // Refused
  input wire        commAck,            // Comm answer
  input wire [15:0] displayScope,       // Selector
  input wire [4:0]  groupCount          // Entries
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Writes in full scope only, so the scope check cannot refuse them
  wire wrAll = panelReq && panelWr && displayScope == 16'h0000;
  wire entRd = panelReq && !panelWr && (panelParam == 16'h00AD || panelParam == 16'h00AE);
  wire cntWr = wrAll && panelParam == 16'h00AC;
  // ========
  // Properties
  a_ack_next: assert property (panelReq |=> panelAck) else $error("no panel answer");
  a_comm_next: assert property (commReq |=> commAck) else $error("no comm answer");
  a_err_write: assert property (writeRejectedError |-> panelAck && !panelAllow && $past(panelWr))
    else $error("bad error");
  a_grant_or_err: assert property (panelAck && $past(panelWr) |-> panelAllow != writeRejectedError)
    else $error("write neither granted nor refused");
  a_entry_read: assert property (entRd |=> !panelAllow || panelRdData == 16'h270F)
    else $error("entry read");
  a_count_max: assert property (groupCount <= 5'h10) else $error("count above 16");
  a_batch_clr: assert property (cntWr && panelWrData == 16'h270F |=> ##1 groupCount == 5'h00)
    else $error("no clear");
  a_count_keep: assert property (cntWr && panelWrData != 16'h270F |=> panelAllow && !writeRejectedError)
    else $error("cnt wr");
  a_rem_none: assert property (wrAll && panelParam == 16'h00AE && panelWrData == 16'h270F |=> panelAllow)
    else $error("rem");
  a_scope_read: assert property (panelReq && !panelWr && panelParam == 16'h00A0
    |=> panelAllow && panelRdData == $past(displayScope)) else $error("scope read");
  c_refused: cover property (writeRejectedError);
  c_full: cover property (groupCount == 5'h10);
  c_cleared: cover property (groupCount == 5'h00 && $past(groupCount) != 5'h00);
endmodule // pugf_filter_asserts

// ---- bench/pugf_panel_model.sv ----
// Purpose: Panel side issuing parameter accesses.
// Assumes: One access at a time, answer one cycle later.
// Notes:   Released number and value lines show the inverse of the last value.
`timescale 1ns/100ps
module pugf_panel_model (
  input  wire        ref_clk,     // Clock
  input  wire        panelAck,    // Answer
  input  wire        panelAllow,  // Granted
  input  wire        panelLocal,  // Served locally
  input  wire        panelErr,    // Write refused
  input  wire [15:0] panelRdData, // Read value
  output reg         panelReq,    // Request
  output reg         panelWr,     // Write
  output reg  [15:0] panelParam,  // Number
  output reg  [15:0] panelWrData, // Value
  output reg         panelSimple  // Simple flag
);
  reg        ak, al, lo, er;
  reg [15:0] rd;
  initial begin
    panelReq = 1'b0;
    panelWr = 1'b0;
    panelParam = 16'h0000;
    panelWrData = 16'h0000;
    panelSimple = 1'b0;
  end
  // ========
  // Access
  task acc(input w, input [15:0] p, input [15:0] d, input s);
    begin
      @(posedge ref_clk);
      panelReq <= 1'b1;
      panelWr <= w;
      panelParam <= p;
      panelWrData <= d;
      panelSimple <= s;
      // Taken at this edge; the answer stands for the next cycle only
      @(posedge ref_clk);
      panelReq <= 1'b0;
      panelParam <= ~p;
      panelWrData <= ~d;
      @(negedge ref_clk);
      ak = panelAck;
      al = panelAllow;
      lo = panelLocal;
      er = panelErr;
      rd = panelRdData;
    end
  endtask
endmodule // pugf_panel_model

// ---- bench/test_pugf_filter.sv ----
// Purpose: Self-checking bench for pugf_filter.
// Assumes: Pins need two edges through their syncs.
// Notes:   Local read data is compared only when granted.
`timescale 1ns/100ps
module test_pugf_filter;
  reg          ref_clk, resetn, commReq, displayUnitPin, optionPin;
  reg  [15:0]  commParam;
  reg  [111:0] prot = {16'h004D, 16'h00A0, 16'h00AC, 16'h00AD, 16'h00AE, 16'h0128, 16'h0129};
  wire         panelReq, panelWr, panelSimple, panelAck, panelAllow, panelLocal;
  wire         writeRejectedError, commAck, commLocal;
  wire [15:0]  panelParam, panelWrData, panelRdData, commRdData, displayScope;
  wire [4:0]   groupCount;
  integer      mismatches, num_checks, i;
  always #50 ref_clk = ~ref_clk;
  pugf_filter u_pugf_filter (.ref_clk(ref_clk), .resetn(resetn), .panelReq(panelReq), .panelWr(panelWr),
    .panelParam(panelParam), .panelWrData(panelWrData), .panelSimple(panelSimple), .commReq(commReq),
    .commParam(commParam), .displayUnitPin(displayUnitPin), .optionPin(optionPin), .panelAck(panelAck),
    .panelAllow(panelAllow), .panelLocal(panelLocal), .panelRdData(panelRdData), .commAck(commAck),
    .writeRejectedError(writeRejectedError), .commLocal(commLocal), .commRdData(commRdData),
    .displayScope(displayScope), .groupCount(groupCount));
  pugf_panel_model u_pugf_panel_model (.ref_clk(ref_clk), .panelAck(panelAck), .panelAllow(panelAllow),
    .panelLocal(panelLocal), .panelErr(writeRejectedError), .panelRdData(panelRdData), .panelReq(panelReq),
    .panelWr(panelWr), .panelParam(panelParam), .panelWrData(panelWrData), .panelSimple(panelSimple));
  // ========
  // Tasks
  task chk(input [15:0] g, input [15:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // A write is granted exactly when it raises no error
  task ta(input w, input [15:0] p, input [15:0] d, input s, input a, input [15:0] x);
    reg lc;
    begin
      lc = p == 16'h00A0 || (p >= 16'h00AC && p <= 16'h00AE);
      u_pugf_panel_model.acc(w, p, d, s);
      chk({15'h0, u_pugf_panel_model.ak}, 16'h0001);
      chk({15'h0, u_pugf_panel_model.al}, {15'h0, a});
      chk({15'h0, u_pugf_panel_model.er}, {15'h0, w & !a});
      if (a) chk({15'h0, u_pugf_panel_model.lo}, {15'h0, lc});
      if (lc && !w && a) chk(u_pugf_panel_model.rd, x);
    end
  endtask
  task rdP(input [15:0] p, input s, input a, input [15:0] x);
    ta(1'b0, p, 16'h0000, s, a, x);
  endtask
  task wrP(input [15:0] p, input [15:0] d, input a);
    ta(1'b1, p, d, 1'b0, a, 16'h0000);
  endtask
  task tc(input [15:0] p, input lc, input [15:0] x);
    begin
      @(posedge ref_clk);
      commReq <= 1'b1;
      commParam <= p;
      @(posedge ref_clk);
      commReq <= 1'b0;
      commParam <= ~p;
      // The answer stands for one cycle only
      @(negedge ref_clk);
      chk({15'h0, commAck}, 16'h0001);
      chk({15'h0, commLocal}, {15'h0, lc});
      chk(commRdData, x);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // ========
  // Sequence
  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    commReq = 1'b0;
    commParam = 16'h0000;
    displayUnitPin = 1'b0;
    optionPin = 1'b0;
    mismatches = 0;
    num_checks = 0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    rdP(16'h00A0, 0, 1, 16'h0000);
    rdP(16'h00AC, 0, 1, 16'h0000);
    rdP(16'h00AD, 0, 1, 16'h270F);
    rdP(16'h00AE, 0, 1, 16'h270F);
    wrP(16'h00A0, 16'h0002, 0);
    chk(displayScope, 16'h0000);
    $display("test 1 done");
    wrP(16'h00AD, 16'h0003, 1);
    wrP(16'h00AD, 16'h0003, 1);
    rdP(16'h00AC, 0, 1, 16'h0001);
    for (i = 0; i < 7; i = i + 1)
      wrP(16'h00AD, prot[i*16 +: 16], 0);
    wrP(16'h00AD, 16'h07D0, 0);
    wrP(16'h00AD, 16'h07CF, 1);
    for (i = 10; i < 24; i = i + 1)
      wrP(16'h00AD, i[15:0], 1);
    rdP(16'h00AC, 0, 1, 16'h0010);
    wrP(16'h00AD, 16'h0019, 0);
    @(negedge ref_clk);
    chk({11'h000, groupCount}, 16'h0010);
    $display("test 2 done");
    wrP(16'h00A0, 16'h0001, 1);
    chk(displayScope, 16'h0001);
    rdP(16'h0003, 0, 1, 16'h0000);
    rdP(16'h01F4, 1, 0, 16'h0000);
    rdP(16'h00AC, 0, 0, 16'h0000);
    wrP(16'h01F4, 16'h0001, 0);
    wrP(16'h0003, 16'h0005, 1);
    rdP(16'h004D, 0, 1, 16'h0000);
    rdP(16'h0128, 0, 1, 16'h0000);
    rdP(16'h0129, 0, 1, 16'h0000);
    rdP(16'h00A0, 0, 1, 16'h0001);
    rdP(16'h03DF, 0, 0, 16'h0000);
    rdP(16'h07D0, 0, 0, 16'h0000);
    @(posedge ref_clk);
    displayUnitPin <= 1'b1;
    optionPin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdP(16'h03DF, 0, 1, 16'h0000);
    rdP(16'h07D0, 0, 1, 16'h0000);
    tc(16'h00A0, 1, 16'h0001);
    tc(16'h00AC, 1, 16'h0010);
    tc(16'h01F4, 0, 16'h0000);
    $display("test 3 done");
    wrP(16'h00A0, 16'h270F, 1);
    rdP(16'h01F4, 1, 1, 16'h0000);
    rdP(16'h01F4, 0, 0, 16'h0000);
    wrP(16'h00A0, 16'h0000, 1);
    rdP(16'h01F4, 0, 1, 16'h0000);
    $display("test 4 done");
    wrP(16'h00AE, 16'h0003, 1);
    rdP(16'h00AC, 0, 1, 16'h000F);
    wrP(16'h00AE, 16'h0003, 1);
    wrP(16'h00AE, 16'h270F, 1);
    wrP(16'h00AC, 16'h0005, 1);
    rdP(16'h00AC, 0, 1, 16'h000F);
    wrP(16'h00AC, 16'h270F, 1);
    rdP(16'h00AC, 0, 1, 16'h0000);
    $display("test 5 done");
    end_of_test;
  end
  // Whole run is about 140 cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    mismatches = mismatches + 1;
    end_of_test;
  end
endmodule // test_pugf_filter
bind pugf_filter pugf_filter_asserts u_pugf_filter_asserts (.*);
